// ===== logic/fcz_pkg.sv
// Purpose: Constants and types for the flash card zone command host.
// Assumes: 100 MHz mclk; card pins are plain logic levels.
// Notes:   Card timing figures are host choices, not card limits.
package fcz_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_ADDR_SETUP_NS = 20;
  localparam int T_STROBE_NS = 100;
  localparam int T_ACCESS_NS = 250;
  localparam int T_HOLD_NS = 20;
  localparam logic [7:0] SETUP_CYC = 8'((T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] READ_LAG_CYC = 8'h03;  // Pin register plus two sync stages
  localparam int ADDR_W = 20;
  localparam logic [7:0] CMD_READ_MEM = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_ERASE_CHECK = 8'ha0;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_WRITE_CHECK = 8'hc0;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [19:0] ID_MAKER_ADDR = 20'h00000;
  localparam logic [19:0] ID_PART_ADDR = 20'h00002;

  typedef enum logic [2:0] {
    FCZ_OP_READ, FCZ_OP_READ_MEM, FCZ_OP_IDENT, FCZ_OP_ERASE,
    FCZ_OP_ERASE_CHECK, FCZ_OP_PROGRAM, FCZ_OP_WRITE_CHECK, FCZ_OP_RESET
  } fcz_op_e;
  typedef enum logic [1:0] {FCZ_LANE_X8, FCZ_LANE_HIGH, FCZ_LANE_X16} fcz_lane_e;
  typedef enum logic [1:0] {FCZ_IDLE, FCZ_SETUP, FCZ_STROBE, FCZ_HOLD} fcz_state_e;
endpackage

// ===== logic/fcz_sync2.sv
// Purpose: Two flip-flop synchroniser for card data inputs.
// Assumes: Card lanes are asynchronous to mclk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
module fcz_sync2 #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Two stage capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ===== logic/fcz_host.sv
// Purpose: Host controller that drives a flash card's zone command latch.
// Assumes: Card pins are registered here; lanes are split into i/o/oe.
// Notes:   Supply level only changes while idle, never inside a sequence.
`timescale 1ns/100ps
module fcz_host (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset,
  // User request
  input  wire logic                 req,
  input  wire fcz_pkg::fcz_op_e     op,
  input  wire fcz_pkg::fcz_lane_e   lane,
  input  wire logic [19:0]          addr,
  input  wire logic [15:0]          wdata,
  input  wire logic                 supply_request,
  // User answer
  output logic                      busy,
  output logic                      done,
  output logic                      refused,
  output logic      [15:0]          rdata,
  output logic      [15:0]          maker_code,
  output logic                      erase_ok,
  output logic      [7:0]           last_command,
  output logic                      supply_ready,
  // Card control pins
  output logic                      low_lane_card_select_n,
  output logic                      high_lane_card_select_n,
  output logic                      output_enable_n,
  output logic                      write_enable_n,
  output logic      [19:1]          card_address,
  output logic                      byte_select_address_bit,
  output logic                      low_lane_program_supply,
  output logic                      high_lane_program_supply,
  // Card data lanes
  input  wire logic [7:0]           lower_data_lane_i,
  output logic      [7:0]           lower_data_lane_o,
  output logic                      lower_data_lane_oe,
  input  wire logic [7:0]           upper_data_lane_i,
  output logic      [7:0]           upper_data_lane_o,
  output logic                      upper_data_lane_oe
);
  fcz_pkg::fcz_state_e state_q;
  fcz_pkg::fcz_op_e    op_q;
  fcz_pkg::fcz_lane_e  lane_q;
  logic [7:0]  cnt_q;
  logic [1:0]  step_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] maker_q;
  logic        erase_ok_q;
  logic [7:0]  last_cmd_q;
  logic        supply_q;
  logic        done_q;
  logic [7:0]  lo_sync;
  logic [7:0]  hi_sync;

  // Card inputs cross into mclk before anything looks at them
  fcz_sync2 #(.W(8)) u_sync_lo (.mclk(mclk), .reset(reset), .d(lower_data_lane_i), .q(lo_sync));
  fcz_sync2 #(.W(8)) u_sync_hi (.mclk(mclk), .reset(reset), .d(upper_data_lane_i), .q(hi_sync));

  // Command code per operation
  wire [7:0] cmd_code =
    (op_q == fcz_pkg::FCZ_OP_IDENT)       ? fcz_pkg::CMD_IDENT :
    (op_q == fcz_pkg::FCZ_OP_ERASE)       ? fcz_pkg::CMD_ERASE :
    (op_q == fcz_pkg::FCZ_OP_ERASE_CHECK) ? fcz_pkg::CMD_ERASE_CHECK :
    (op_q == fcz_pkg::FCZ_OP_PROGRAM)     ? fcz_pkg::CMD_PROGRAM :
    (op_q == fcz_pkg::FCZ_OP_WRITE_CHECK) ? fcz_pkg::CMD_WRITE_CHECK :
    (op_q == fcz_pkg::FCZ_OP_RESET)       ? fcz_pkg::CMD_RESET :
    fcz_pkg::CMD_READ_MEM;

  // Step decode: ident is write, read, read; checks are write, read
  wire single_step = (op_q == fcz_pkg::FCZ_OP_READ) || (op_q == fcz_pkg::FCZ_OP_READ_MEM);
  wire [1:0] last_step = single_step ? 2'h0 : (op_q == fcz_pkg::FCZ_OP_IDENT) ? 2'h2 : 2'h1;
  wire is_check = (op_q == fcz_pkg::FCZ_OP_ERASE_CHECK) || (op_q == fcz_pkg::FCZ_OP_WRITE_CHECK);
  wire step_rd = (op_q == fcz_pkg::FCZ_OP_READ)
              || (op_q == fcz_pkg::FCZ_OP_IDENT && step_q != 2'h0)
              || (is_check && step_q == 2'h1);
  wire payload_step = (op_q == fcz_pkg::FCZ_OP_PROGRAM) && (step_q == 2'h1);
  wire [15:0] step_data = payload_step ? wdata_q : {cmd_code, cmd_code};
  wire [19:0] step_addr =
    (op_q == fcz_pkg::FCZ_OP_IDENT && step_q == 2'h1) ? fcz_pkg::ID_MAKER_ADDR :
    (op_q == fcz_pkg::FCZ_OP_IDENT && step_q == 2'h2) ? fcz_pkg::ID_PART_ADDR :
    addr_q;

  // Lane enables from the requested width
  wire lo_en = (lane_q != fcz_pkg::FCZ_LANE_HIGH);
  wire hi_en = (lane_q != fcz_pkg::FCZ_LANE_X8);
  wire active = (state_q != fcz_pkg::FCZ_IDLE);
  wire strobe = (state_q == fcz_pkg::FCZ_STROBE);
  wire tick = (cnt_q == 8'h00);

  // Request acceptance; anything but a plain read needs high supply
  wire needs_supply = (op != fcz_pkg::FCZ_OP_READ);
  wire idle_req = req && !active;
  wire accept = idle_req && !(needs_supply && !supply_q);
  assign refused = idle_req && needs_supply && !supply_q;
  assign busy = active;
  assign done = done_q;
  assign rdata = rdata_q;
  assign maker_code = maker_q;
  assign erase_ok = erase_ok_q;
  assign last_command = last_cmd_q;
  assign supply_ready = supply_q;

  // Sampled read word, disabled lanes read as zero
  wire [15:0] rd_word = {hi_sync & {8{hi_en}}, lo_sync & {8{lo_en}}};
  wire rd_sample = strobe && tick && step_rd;
  wire all_erased = (!lo_en || lo_sync == fcz_pkg::ERASED_BYTE)
                 && (!hi_en || hi_sync == fcz_pkg::ERASED_BYTE);

  // Sequencer: setup, strobe, hold per bus cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= fcz_pkg::FCZ_IDLE;
      cnt_q   <= 8'h00;
      step_q  <= 2'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        fcz_pkg::FCZ_IDLE: begin
          if (accept) begin
            state_q <= fcz_pkg::FCZ_SETUP;
            cnt_q   <= fcz_pkg::SETUP_CYC - 8'h01;
            step_q  <= 2'h0;
          end
        end
        fcz_pkg::FCZ_SETUP: begin
          if (tick) begin
            state_q <= fcz_pkg::FCZ_STROBE;
            cnt_q   <= step_rd ? fcz_pkg::ACCESS_CYC + fcz_pkg::READ_LAG_CYC - 8'h01
                               : fcz_pkg::STROBE_CYC - 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fcz_pkg::FCZ_STROBE: begin
          if (tick) begin
            state_q <= fcz_pkg::FCZ_HOLD;
            cnt_q   <= fcz_pkg::HOLD_CYC - 8'h01;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        fcz_pkg::FCZ_HOLD: begin
          if (!tick) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (step_q == last_step) begin
            state_q <= fcz_pkg::FCZ_IDLE;
            done_q  <= 1'b1;
          end else begin
            state_q <= fcz_pkg::FCZ_SETUP;
            cnt_q   <= fcz_pkg::SETUP_CYC - 8'h01;
            step_q  <= step_q + 2'h1;
          end
        end
      endcase
    end
  end

  // Request capture; address held for the whole sequence
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_q    <= fcz_pkg::FCZ_OP_READ;
      lane_q  <= fcz_pkg::FCZ_LANE_X8;
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
    end else if (accept) begin
      op_q    <= op;
      lane_q  <= lane;
      addr_q  <= addr;
      wdata_q <= wdata;
    end
  end

  // Read results; first identifier read is the maker code
  always_ff @(posedge mclk) begin
    if (reset) begin
      rdata_q    <= 16'h0000;
      maker_q    <= 16'h0000;
      erase_ok_q <= 1'b0;
    end else if (rd_sample) begin
      if (op_q == fcz_pkg::FCZ_OP_IDENT && step_q == 2'h1) maker_q <= rd_word;
      else rdata_q <= rd_word;
      if (op_q == fcz_pkg::FCZ_OP_ERASE_CHECK) erase_ok_q <= all_erased;
    end
  end

  // Supply only moves while idle; dropping it returns the latch to read
  always_ff @(posedge mclk) begin
    if (reset) begin
      supply_q   <= 1'b0;
      last_cmd_q <= fcz_pkg::CMD_READ_MEM;
    end else if (!active && !req) begin
      supply_q <= supply_request;
      if (!supply_request) last_cmd_q <= fcz_pkg::CMD_READ_MEM;
    end else if (strobe && tick && !step_rd && !payload_step) begin
      last_cmd_q <= cmd_code;
    end
  end

  // Pin drive; output enable stays high whenever data is driven
  wire ce_lo_n_d = !(active && lo_en);
  wire ce_hi_n_d = !(active && hi_en);
  wire we_n_d = !(strobe && !step_rd);
  wire oe_n_d = !(strobe && step_rd);
  wire drive_d = active && !step_rd;
  always_ff @(posedge mclk) begin
    if (reset) begin
      low_lane_card_select_n  <= 1'b1;
      high_lane_card_select_n <= 1'b1;
      write_enable_n          <= 1'b1;
      output_enable_n         <= 1'b1;
      card_address            <= 19'h00000;
      byte_select_address_bit <= 1'b0;
      lower_data_lane_o       <= 8'h00;
      upper_data_lane_o       <= 8'h00;
      lower_data_lane_oe      <= 1'b0;
      upper_data_lane_oe      <= 1'b0;
    end else begin
      low_lane_card_select_n  <= ce_lo_n_d;
      high_lane_card_select_n <= ce_hi_n_d;
      write_enable_n          <= we_n_d;
      output_enable_n         <= oe_n_d;
      {card_address, byte_select_address_bit} <= step_addr;
      lower_data_lane_o       <= step_data[7:0];
      upper_data_lane_o       <= step_data[15:8];
      lower_data_lane_oe      <= drive_d && lo_en;
      upper_data_lane_oe      <= drive_d && hi_en;
    end
  end
  assign low_lane_program_supply = supply_q;
  assign high_lane_program_supply = supply_q;

  // Checks on the pin sequence, request refusal, latch code and completion
  a_we_needs_ce: assert property (@(posedge mclk) disable iff (reset)
    !write_enable_n |-> !(low_lane_card_select_n && high_lane_card_select_n))
    else $error("write strobe low with no card select");
  a_addr_held_strobe: assert property (@(posedge mclk) disable iff (reset)
    (!write_enable_n && !$past(write_enable_n)) |-> $stable(card_address) && $stable(byte_select_address_bit))
    else $error("address moved during write strobe");
  a_data_held_rise: assert property (@(posedge mclk) disable iff (reset)
    $rose(write_enable_n) |-> ($stable(lower_data_lane_o) && $stable(upper_data_lane_o))
      ##1 (lower_data_lane_oe || upper_data_lane_oe))
    else $error("write data not held over strobe rise");
  a_oe_off_drive: assert property (@(posedge mclk) disable iff (reset)
    (lower_data_lane_oe || upper_data_lane_oe || !write_enable_n) |-> output_enable_n)
    else $error("card output enabled while host drives");
  a_refuse_low_supply: assert property (@(posedge mclk) disable iff (reset)
    (req && !active && op != fcz_pkg::FCZ_OP_READ && !supply_q) |-> refused ##1 !busy)
    else $error("modify request taken with supply low");
  a_latch_default: assert property (@(posedge mclk) disable iff (reset)
    $fell(supply_q) |-> last_cmd_q == fcz_pkg::CMD_READ_MEM)
    else $error("latch not read code after supply drop");
  a_word_both_sel: assert property (@(posedge mclk) disable iff (reset)
    (strobe && lane_q == fcz_pkg::FCZ_LANE_X16) |=> !low_lane_card_select_n && !high_lane_card_select_n)
    else $error("word access without both selects");
  a_high_lane_only: assert property (@(posedge mclk) disable iff (reset)
    (active && lane_q == fcz_pkg::FCZ_LANE_HIGH) |=> low_lane_card_select_n && !lower_data_lane_oe)
    else $error("lower lane used in high lane access");
  a_byte_even_odd: assert property (@(posedge mclk) disable iff (reset)
    (strobe && lane_q == fcz_pkg::FCZ_LANE_X8)
      |=> high_lane_card_select_n && byte_select_address_bit == $past(step_addr[0]))
    else $error("byte access select or parity wrong");
  a_ident_part_addr: assert property (@(posedge mclk) disable iff (reset)
    (strobe && op_q == fcz_pkg::FCZ_OP_IDENT && step_q == 2'h2)
      |=> {card_address, byte_select_address_bit} == fcz_pkg::ID_PART_ADDR)
    else $error("part code read at wrong address");
  a_zone_addr_kept: assert property (@(posedge mclk) disable iff (reset)
    (strobe && op_q != fcz_pkg::FCZ_OP_IDENT) |=> {card_address, byte_select_address_bit} == addr_q)
    else $error("access address differs from request");
  a_seq_finishes: assert property (@(posedge mclk) disable iff (reset)
    accept |-> ##[14:200] done)
    else $error("command sequence did not finish");
endmodule

// ===== bench/fcz_card_model.sv
// Purpose: Behavioural flash card that answers the host's control pins and lanes.
// Assumes: One command latch stands for every zone; the array is 16 words.
// Notes:   A released lane shows the inverse of its last value, as there is no pull.
`timescale 1ns/100ps
module fcz_card_model #(
  parameter logic [15:0] MAKER_WORD = 16'h5a5a,  // Arbitrary value
  parameter logic [15:0] PART_WORD  = 16'h3c3c   // Arbitrary value
) (
  // Control pins
  input  wire logic        low_lane_card_select_n,
  input  wire logic        high_lane_card_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic [19:1] card_address,
  input  wire logic        byte_select_address_bit,
  input  wire logic        low_lane_program_supply,
  input  wire logic        high_lane_program_supply,
  // Lanes as resolved on the wire, and the card's own drive
  input  wire logic [7:0]  lower_wire,
  input  wire logic [7:0]  upper_wire,
  output logic      [7:0]  lower_data_lane,
  output logic      [7:0]  upper_data_lane
);
  logic [7:0]  latch_q;
  logic [7:0]  cmd;
  logic [15:0] mem [16];
  logic [19:0] wa_q;
  logic [7:0]  lo_last;
  logic [7:0]  hi_last;
  // Pin decode; the latch itself is never a read source
  wire         lo_sel    = !low_lane_card_select_n;
  wire         hi_sel    = !high_lane_card_select_n;
  wire         supply_hi = low_lane_program_supply && high_lane_program_supply;
  wire  [19:0] pin_addr  = {card_address, byte_select_address_bit};
  wire         odd_x8    = lo_sel && !hi_sel && byte_select_address_bit;
  wire  [15:0] id_word   = (pin_addr == 20'h00000) ? MAKER_WORD : PART_WORD;
  wire  [15:0] word      = (latch_q == 8'h90) ? id_word : mem[pin_addr[4:1]];
  wire  [7:0]  lo_val    = odd_x8 ? word[15:8] : word[7:0];
  wire         lo_drv    = !output_enable_n && lo_sel;
  wire         hi_drv    = !output_enable_n && hi_sel;
  assign lower_data_lane = lo_drv ? lo_val : ~lo_last;
  assign upper_data_lane = hi_drv ? word[15:8] : ~hi_last;
  // Array starts in a pattern that the bench predicts
  initial begin
    latch_q = 8'h00;
    lo_last = 8'h00;
    hi_last = 8'h00;
    for (int i = 0; i < 16; i++) mem[i] = {4'(i), 4'h1, 4'(i), 4'h2};
  end
  // Remember what each lane last drove
  always @* if (lo_drv) lo_last = lo_val;
  always @* if (hi_drv) hi_last = word[15:8];
  // Address is caught as the strobe falls
  always @(negedge write_enable_n) wa_q = pin_addr;
  // Data is caught as the strobe rises; a low supply pins the latch to the read code
  always @(posedge write_enable_n or negedge supply_hi) begin
    if (!supply_hi) begin
      latch_q = 8'h00;
    end else if (lo_sel || hi_sel) begin
      cmd = lo_sel ? lower_wire : upper_wire;
      if (latch_q == 8'h40) begin
        if (odd_x8) mem[wa_q[4:1]][15:8] = lower_wire;
        else begin
          if (lo_sel) mem[wa_q[4:1]][7:0] = lower_wire;
          if (hi_sel) mem[wa_q[4:1]][15:8] = upper_wire;
        end
        latch_q = 8'h00;
      end else if (latch_q == 8'h20 && cmd == 8'h20) begin
        for (int i = 0; i < 16; i++) mem[i] = 16'hffff;
        latch_q = 8'h21;
      end else if (latch_q == 8'hff && cmd == 8'hff) begin
        latch_q = 8'h00;
      end else begin
        latch_q = cmd;
      end
    end
  end
endmodule

// ===== bench/fcz_host_bench.sv
// Purpose: Self-checking bench for the zone command host against a card model.
// Assumes: Card array word i starts as nibbles {i,1,i,2}.
// Notes:   Every wait is bounded so a stuck sequence still ends the run.
`timescale 1ns/100ps
module fcz_host_bench;
  localparam logic [15:0] MAKER = 16'h5a5a;  // Arbitrary value
  localparam logic [15:0] PART  = 16'h3c3c;  // Arbitrary value
  logic               mclk, reset, req, supply_request;
  fcz_pkg::fcz_op_e   op;
  fcz_pkg::fcz_lane_e lane;
  logic [19:0]        addr;
  logic [15:0]        wdata, rdata, maker_code;
  logic               busy, done, refused, erase_ok, supply_ready;
  logic [7:0]         last_command;
  logic               low_lane_card_select_n, high_lane_card_select_n, output_enable_n, write_enable_n;
  logic [19:1]        card_address;
  logic               byte_select_address_bit, low_lane_program_supply, high_lane_program_supply;
  logic [7:0]         lower_data_lane_o, upper_data_lane_o, card_lower, card_upper;
  logic               lower_data_lane_oe, upper_data_lane_oe;
  int                 error_cnt = 0;
  int                 n_checks = 0;
  // Whoever enables its drive owns the lane
  wire  [7:0]         lower_wire = lower_data_lane_oe ? lower_data_lane_o : card_lower;
  wire  [7:0]         upper_wire = upper_data_lane_oe ? upper_data_lane_o : card_upper;

  fcz_host dut (.lower_data_lane_i(lower_wire), .upper_data_lane_i(upper_wire), .*);
  fcz_card_model #(.MAKER_WORD(MAKER), .PART_WORD(PART)) card (
    .lower_data_lane(card_lower), .upper_data_lane(card_upper), .*);

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One operation: held for its accept edge, then done is awaited
  task automatic run(input fcz_pkg::fcz_op_e o, input fcz_pkg::fcz_lane_e l,
                     input logic [19:0] a, input logic [15:0] d);
    int k;
    @(posedge mclk);
    req <= 1'b1;
    op <= o;
    lane <= l;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    req <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 200);
    if (k >= 200) begin
      error_cnt++;
      print_verdict();
    end
  endtask

  // A modifying request with low supply is turned away at once
  task automatic t_refuse(input fcz_pkg::fcz_op_e o);
    @(posedge mclk);
    req <= 1'b1;
    op <= o;
    #1;
    check({15'h0, refused}, 16'h0001);
    @(posedge mclk);
    req <= 1'b0;
    #1;
    check({15'h0, busy}, 16'h0000);
  endtask

  task automatic set_supply(input logic v);
    int k;
    @(posedge mclk);
    supply_request <= v;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (supply_ready !== v && k < 50);
    if (k >= 50) begin
      error_cnt++;
      print_verdict();
    end
    check({14'h0, low_lane_program_supply, high_lane_program_supply}, {14'h0, v, v});
  endtask

  // Low supply: every lane mode reads, nothing modifies
  task automatic t_read_only();
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X16, 20'h00008, 16'h0000);
    check(rdata, 16'h4142);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X8, 20'h00008, 16'h0000);
    check(rdata, 16'h0042);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X8, 20'h00009, 16'h0000);
    check(rdata, 16'h0041);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_HIGH, 20'h00009, 16'h0000);
    check(rdata, 16'h4100);
    t_refuse(fcz_pkg::FCZ_OP_PROGRAM);
    t_refuse(fcz_pkg::FCZ_OP_ERASE);
    t_refuse(fcz_pkg::FCZ_OP_IDENT);
    check({8'h00, last_command}, 16'h0000);
  endtask

  task automatic t_ident();
    set_supply(1'b1);
    run(fcz_pkg::FCZ_OP_IDENT, fcz_pkg::FCZ_LANE_X16, 20'h00000, 16'h0000);
    check(maker_code, MAKER);
    check(rdata, PART);
    check({8'h00, last_command}, 16'h0090);
    check({card_address[15:1], byte_select_address_bit}, 16'h0002);
  endtask

  // Byte writes through the x8 lane mode (even and odd address) and the high lane mode land in the right half of the word
  task automatic t_program();
    run(fcz_pkg::FCZ_OP_PROGRAM, fcz_pkg::FCZ_LANE_X8, 20'h00004, 16'h00a5);
    run(fcz_pkg::FCZ_OP_PROGRAM, fcz_pkg::FCZ_LANE_X8, 20'h00005, 16'h005a);
    run(fcz_pkg::FCZ_OP_PROGRAM, fcz_pkg::FCZ_LANE_HIGH, 20'h00006, 16'h3c00);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h0000);
    check(rdata, 16'h5aa5);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X16, 20'h00006, 16'h0000);
    check(rdata, 16'h3c32);
    run(fcz_pkg::FCZ_OP_WRITE_CHECK, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h0000);
    check(rdata, 16'h5aa5);
    check({8'h00, last_command}, 16'h00c0);
  endtask

  // Erase, pass and fail of the check, then back to plain reads
  task automatic t_erase();
    run(fcz_pkg::FCZ_OP_ERASE, fcz_pkg::FCZ_LANE_X16, 20'h00000, 16'h0000);
    check({8'h00, last_command}, 16'h0020);
    run(fcz_pkg::FCZ_OP_ERASE_CHECK, fcz_pkg::FCZ_LANE_X16, 20'h00008, 16'h0000);
    check({15'h0, erase_ok}, 16'h0001);
    check(rdata, 16'hffff);
    run(fcz_pkg::FCZ_OP_PROGRAM, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h1234);
    run(fcz_pkg::FCZ_OP_ERASE_CHECK, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h0000);
    check({15'h0, erase_ok}, 16'h0000);
    run(fcz_pkg::FCZ_OP_READ_MEM, fcz_pkg::FCZ_LANE_X16, 20'h00000, 16'h0000);
    check({8'h00, last_command}, 16'h0000);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h0000);
    check(rdata, 16'h1234);
  endtask

  task automatic t_supply_drop();
    run(fcz_pkg::FCZ_OP_RESET, fcz_pkg::FCZ_LANE_X16, 20'h00000, 16'h0000);
    check({8'h00, last_command}, 16'h00ff);
    set_supply(1'b0);
    check({8'h00, last_command}, 16'h0000);
    t_refuse(fcz_pkg::FCZ_OP_RESET);
    run(fcz_pkg::FCZ_OP_READ, fcz_pkg::FCZ_LANE_X16, 20'h00004, 16'h0000);
    check(rdata, 16'h1234);
    check({card_address[15:1], byte_select_address_bit}, 16'h0004);
  endtask

  initial begin
    reset = 1'b1;
    req = 1'b0;
    op = fcz_pkg::FCZ_OP_READ;
    lane = fcz_pkg::FCZ_LANE_X16;
    addr = 20'h00000;
    wdata = 16'h0000;
    supply_request = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    check({13'h0, write_enable_n, low_lane_card_select_n, high_lane_card_select_n}, 16'h0007);
    check({14'h0, output_enable_n, lower_data_lane_oe | upper_data_lane_oe}, 16'h0002);
    check({8'h00, last_command}, 16'h0000);
    t_read_only();
    t_ident();
    t_program();
    t_erase();
    t_supply_drop();
    print_verdict();
  end
endmodule
